//--- link_setup_pkg.sv
// Constants for the split link setup and bring-up block
package link_setup_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // Register offsets (word index on the plain register port)
  localparam logic [3:0] OFS_LO_STATUS = 4'h0;
  localparam logic [3:0] OFS_LO_CONFIG = 4'h1;
  localparam logic [3:0] OFS_HI_STATUS = 4'h2;
  localparam logic [3:0] OFS_HI_CONFIG = 4'h3;
  localparam logic [3:0] OFS_MODE      = 4'h4;
  // Config fields: rate [1:0], width out [4], width in [5], downstream [8]
  localparam int CFG_RATE_LSB  = 0;
  localparam int CFG_WOUT_BIT  = 4;
  localparam int CFG_WIN_BIT   = 5;
  localparam int CFG_DOWN_BIT  = 8;
  // Status fields: init done [0], width out [4], width in [5], rate [9:8]
  localparam int ST_DONE_BIT   = 0;
  localparam int ST_WOUT_BIT   = 4;
  localparam int ST_WIN_BIT    = 5;
  localparam int ST_RATE_LSB   = 8;
  // Rate codes
  localparam logic [1:0] RATE_200 = 2'h0;
  localparam logic [1:0] RATE_400 = 2'h1;
  localparam logic [1:0] RATE_800 = 2'h2;
  // Width codes
  localparam logic WIDTH_8  = 1'b0;
  localparam logic WIDTH_16 = 1'b1;
  // Reset values
  localparam logic [1:0] RATE_RESET  = RATE_200;
  localparam logic       WIDTH_RESET = WIDTH_8;
  // Bring-up timing
  localparam int CLK_PERIOD_NS     = 10;
  localparam int RESET_HOLD_NS     = 1000;
  localparam int RESET_HOLD_CYCLES =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRAIN_EDGES       = 16;
  localparam int CNT_W             = 12;
  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_TRAIN = 4'h2,
    ST_DONE  = 4'h4,
    ST_STOP  = 4'h8
  } link_state_t;
endpackage

//--- link_ctl_if.sv
// Interface between the top and one half-link controller
`timescale 1ns/1ps
`default_nettype none
interface link_ctl_if;
  import link_setup_pkg::*;
  logic       enable;
  logic       master;
  logic [1:0] rate_cfg;
  logic       wout_cfg;
  logic       win_cfg;
  logic       reinit;
  logic       link_clk_edge;
  logic       peer_power_good;
  logic       peer_reset_n;
  logic       peer_stop_n;
  logic       init_done;
  logic [1:0] rate_now;
  logic       wout_now;
  logic       win_now;
  logic       drv_power_good;
  logic       drv_reset_n;
  logic       drv_stop_n;
  modport top  (output enable, master, rate_cfg, wout_cfg, win_cfg,
                reinit, link_clk_edge, peer_power_good, peer_reset_n,
                peer_stop_n,
                input init_done, rate_now, wout_now, win_now,
                drv_power_good, drv_reset_n, drv_stop_n);
  modport ctl  (input enable, master, rate_cfg, wout_cfg, win_cfg,
                reinit, link_clk_edge, peer_power_good, peer_reset_n,
                peer_stop_n,
                output init_done, rate_now, wout_now, win_now,
                drv_power_good, drv_reset_n, drv_stop_n);
endinterface
`default_nettype wire

//--- half_link_ctl.sv
// One half-link controller: reset, training and reprogramming
`timescale 1ns/1ps
`default_nettype none
module half_link_ctl
  import link_setup_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link controls
  link_ctl_if.ctl  c
);
  link_state_t      state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [1:0]       rate_r, rate_nxt;
  logic             wout_r, wout_nxt;
  logic             win_r, win_nxt;
  logic             lnk_rst_n, lnk_stop_n, lnk_pg;
  logic             own_rst_n;

  // Sideband as seen on the wire: own drive or peer's
  always_comb begin
    // Own reset rises once the hold count is reached
    own_rst_n  = (state_r != ST_RESET) ||
                 (cnt_r >= CNT_W'(RESET_HOLD_CYCLES));
    lnk_pg     = c.master ? 1'b1 : c.peer_power_good;
    lnk_rst_n  = c.master ? own_rst_n : c.peer_reset_n;
    lnk_stop_n = c.master ? (state_r != ST_STOP) : c.peer_stop_n;
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    rate_nxt  = rate_r;
    wout_nxt  = wout_r;
    win_nxt   = win_r;
    unique case (state_r)
      ST_RESET: begin
        if (c.master) begin
          if (cnt_r < CNT_W'(RESET_HOLD_CYCLES)) cnt_nxt = cnt_r + 1'b1;
        end
        if (c.enable && lnk_pg && lnk_rst_n &&
            (!c.master || cnt_r >= CNT_W'(RESET_HOLD_CYCLES))) begin
          // New settings load only at re-initialization
          rate_nxt  = c.rate_cfg;
          wout_nxt  = c.wout_cfg;
          win_nxt   = c.win_cfg;
          cnt_nxt   = '0;
          state_nxt = ST_TRAIN;
        end
      end
      ST_TRAIN: begin
        if (c.link_clk_edge) cnt_nxt = cnt_r + 1'b1;
        if (cnt_r >= CNT_W'(TRAIN_EDGES)) state_nxt = ST_DONE;
      end
      ST_DONE: begin
        if (c.master && c.reinit) state_nxt = ST_STOP;
      end
      ST_STOP: begin
        cnt_nxt = '0;
        if (!c.reinit) state_nxt = ST_RESET;
      end
      default: state_nxt = ST_RESET;
    endcase
    // Peer-driven reset or stop forces re-initialization
    if (!c.enable || !lnk_pg || !lnk_rst_n ||
        (!lnk_stop_n && state_r != ST_STOP)) begin
      state_nxt = ST_RESET;
      // Own hold count must keep running while own reset is low
      if (!c.enable || (!c.master && !lnk_rst_n)) cnt_nxt = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RESET;
      cnt_r   <= '0;
      rate_r  <= RATE_RESET;
      wout_r  <= WIDTH_RESET;
      win_r   <= WIDTH_RESET;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      rate_r  <= rate_nxt;
      wout_r  <= wout_nxt;
      win_r   <= win_nxt;
    end
  end

  assign c.init_done      = (state_r == ST_DONE);
  assign c.rate_now       = rate_r;
  assign c.wout_now       = wout_r;
  assign c.win_now        = win_r;
  assign c.drv_power_good = 1'b1;
  assign c.drv_reset_n    = own_rst_n;
  assign c.drv_stop_n     = (state_r != ST_STOP);
endmodule
`default_nettype wire

//--- link_setup_top.sv
// Split 16-bit link: lane ownership, straps, setup registers, bring-up
//
// Functional notes
// - Split strap 1: two 8-bit links; address bit 40 picks high half.
// - Split strap 0: one 16-bit link run by low controller only.
// - Unsplit: all high controller signals are ignored as invalid.
// - Master strap 1: that half drives power-good, reset and stop.
// - Downstream-role bit loads as inverse of that half's master strap.
// - Bridge bit sent is inverse of the downstream-role bit.
// - Window miss: peer-to-peer resend if role 0, error answer if 1.
// - Split: clock lane 1 high, lane 0 low; unsplit: both low.
// - Split: control lane 1 high, 0 low; unsplit: lane 1 unused.
// - Split: data 15:8 high, 7:0 low; unsplit: all sixteen low.
// - Auto-initialize after reset_n at 200 MHz, 8 bits.
// - Readable init-done and negotiated outbound and inbound widths.
// - After init software may program widths and rate; peer must match.
// - New width and rate apply only after reset or stop re-init.
// - Rates 200, 400, 800 MHz; widths 8 or 16; max 16 at 800.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module link_setup_top
  import link_setup_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // Straps
  input  wire logic              split_link_strap,
  input  wire logic              low_link_master_strap,
  input  wire logic              high_link_master_strap,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Link clocks (lane 0 low half, lane 1 high half when split) and sideband, low half
  input  wire logic [1:0]        link_clk_in,
  input  wire logic              low_link_power_good_in,
  output logic                   low_link_power_good_out,
  output logic                   low_link_power_good_oe,
  input  wire logic              low_link_reset_n_in,
  output logic                   low_link_reset_n_out,
  output logic                   low_link_reset_n_oe,
  input  wire logic              low_link_stop_n_in,
  output logic                   low_link_stop_n_out,
  output logic                   low_link_stop_n_oe,
  // Sideband, high half
  input  wire logic              high_link_power_good_in,
  output logic                   high_link_power_good_out,
  output logic                   high_link_power_good_oe,
  input  wire logic              high_link_reset_n_in,
  output logic                   high_link_reset_n_out,
  output logic                   high_link_reset_n_oe,
  input  wire logic              high_link_stop_n_in,
  output logic                   high_link_stop_n_out,
  output logic                   high_link_stop_n_oe,
  // Request routing from the packet path
  input  wire logic              req_addr_bit40,
  input  wire logic              rx_window_miss,
  output logic                   sel_high_ctl,
  output logic                   bridge_bit_low,
  output logic                   bridge_bit_high,
  output logic                   miss_p2p_resend,
  output logic                   miss_error_resp,
  // Lane ownership: on clk_lane_high, ctl_lane1_high and cad_upper_high 1 means high controller owns the lane
  output logic [1:0]             clk_lane_high,
  output logic                   ctl_lane1_used,
  output logic                   ctl_lane1_high,
  output logic                   cad_upper_high,
  output logic                   link_width_16
);
  link_ctl_if lo_if ();
  link_ctl_if hi_if ();

  logic        rst_s1_r, rst_n_r;
  logic        straps_taken_r, straps_taken_nxt;
  logic        split_r, split_nxt;
  logic        lo_master_r, lo_master_nxt;
  logic        hi_master_r, hi_master_nxt;
  logic        lo_down_r, lo_down_nxt;
  logic        hi_down_r, hi_down_nxt;
  logic [1:0]  lo_rate_r, lo_rate_nxt, hi_rate_r, hi_rate_nxt;
  logic        lo_wout_r, lo_wout_nxt, lo_win_r, lo_win_nxt;
  logic        hi_wout_r, hi_wout_nxt, hi_win_r, hi_win_nxt;
  logic        lo_reinit_r, lo_reinit_nxt, hi_reinit_r, hi_reinit_nxt;
  logic [DATA_W-1:0] rdata_nxt;
  // Pin synchronisers: link clocks and six sideband inputs
  logic [7:0]  pin_s1_r, pin_s2_r, pin_raw;
  logic [1:0]  lclk_last_r;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  assign pin_raw = {high_link_stop_n_in, high_link_reset_n_in,
                    high_link_power_good_in, low_link_stop_n_in,
                    low_link_reset_n_in, low_link_power_good_in,
                    link_clk_in};

  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_s1_r    <= 8'h00;
      pin_s2_r    <= 8'h00;
      lclk_last_r <= 2'h0;
    end else begin
      pin_s1_r    <= pin_raw;
      pin_s2_r    <= pin_s1_r;
      lclk_last_r <= pin_s2_r[1:0];
    end
  end

  // Legal rate codes only; an illegal write keeps the old value
  function automatic logic [1:0] pick_rate(input logic [1:0] wr,
                                           input logic [1:0] old);
    pick_rate = (wr == RATE_200 || wr == RATE_400 || wr == RATE_800)
                ? wr : old;
  endfunction

  function automatic logic [DATA_W-1:0] status_word(
      input logic done, input logic wo, input logic wi,
      input logic [1:0] rt);
    status_word = '0;
    status_word[ST_DONE_BIT] = done;
    status_word[ST_WOUT_BIT] = wo;
    status_word[ST_WIN_BIT]  = wi;
    status_word[ST_RATE_LSB +: 2] = rt;
  endfunction

  function automatic logic [DATA_W-1:0] config_word(
      input logic [1:0] rt, input logic wo, input logic wi,
      input logic dn);
    config_word = '0;
    config_word[CFG_RATE_LSB +: 2] = rt;
    config_word[CFG_WOUT_BIT] = wo;
    config_word[CFG_WIN_BIT]  = wi;
    config_word[CFG_DOWN_BIT] = dn;
  endfunction

  always_comb begin
    straps_taken_nxt = 1'b1;
    split_nxt     = straps_taken_r ? split_r : split_link_strap;
    lo_master_nxt = straps_taken_r ? lo_master_r : low_link_master_strap;
    hi_master_nxt = straps_taken_r ? hi_master_r : high_link_master_strap;
    lo_down_nxt   = straps_taken_r ? lo_down_r : !low_link_master_strap;
    hi_down_nxt   = straps_taken_r ? hi_down_r
                                   : !high_link_master_strap;
    lo_rate_nxt   = lo_rate_r;
    lo_wout_nxt   = lo_wout_r;
    lo_win_nxt    = lo_win_r;
    hi_rate_nxt   = hi_rate_r;
    hi_wout_nxt   = hi_wout_r;
    hi_win_nxt    = hi_win_r;
    lo_reinit_nxt = lo_reinit_r;
    hi_reinit_nxt = hi_reinit_r;
    rdata_nxt     = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_LO_CONFIG: begin
          lo_rate_nxt = pick_rate(reg_wdata[CFG_RATE_LSB +: 2],
                                  lo_rate_r);
          lo_wout_nxt = reg_wdata[CFG_WOUT_BIT];
          lo_win_nxt  = reg_wdata[CFG_WIN_BIT];
          lo_down_nxt = reg_wdata[CFG_DOWN_BIT];
        end
        OFS_HI_CONFIG: begin
          hi_rate_nxt = pick_rate(reg_wdata[CFG_RATE_LSB +: 2],
                                  hi_rate_r);
          hi_wout_nxt = reg_wdata[CFG_WOUT_BIT];
          hi_win_nxt  = reg_wdata[CFG_WIN_BIT];
          hi_down_nxt = reg_wdata[CFG_DOWN_BIT];
        end
        OFS_MODE: begin
          // Bit 0 / 1 hold stop low on the low / high half when that half is master
          lo_reinit_nxt = reg_wdata[0];
          hi_reinit_nxt = reg_wdata[1];
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_LO_STATUS: rdata_nxt = status_word(lo_if.init_done,
                          lo_if.wout_now, lo_if.win_now, lo_if.rate_now);
        OFS_LO_CONFIG: rdata_nxt = config_word(lo_rate_r, lo_wout_r,
                          lo_win_r, lo_down_r);
        OFS_HI_STATUS: rdata_nxt = split_r ? status_word(hi_if.init_done,
                          hi_if.wout_now, hi_if.win_now, hi_if.rate_now)
                          : '0;
        OFS_HI_CONFIG: rdata_nxt = config_word(hi_rate_r, hi_wout_r,
                          hi_win_r, hi_down_r);
        OFS_MODE:      rdata_nxt = {24'h000000, 1'b0, hi_master_r,
                          lo_master_r, split_r, 2'h0, hi_reinit_r,
                          lo_reinit_r};
        default:       rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      straps_taken_r <= 1'b0;
      split_r        <= 1'b0;
      lo_master_r    <= 1'b0;
      hi_master_r    <= 1'b0;
      lo_down_r      <= 1'b0;
      hi_down_r      <= 1'b0;
      lo_rate_r      <= RATE_RESET;
      lo_wout_r      <= WIDTH_RESET;
      lo_win_r       <= WIDTH_RESET;
      hi_rate_r      <= RATE_RESET;
      hi_wout_r      <= WIDTH_RESET;
      hi_win_r       <= WIDTH_RESET;
      lo_reinit_r    <= 1'b0;
      hi_reinit_r    <= 1'b0;
      reg_rdata      <= '0;
    end else begin
      straps_taken_r <= straps_taken_nxt;
      split_r        <= split_nxt;
      lo_master_r    <= lo_master_nxt;
      hi_master_r    <= hi_master_nxt;
      lo_down_r      <= lo_down_nxt;
      hi_down_r      <= hi_down_nxt;
      lo_rate_r      <= lo_rate_nxt;
      lo_wout_r      <= lo_wout_nxt;
      lo_win_r       <= lo_win_nxt;
      hi_rate_r      <= hi_rate_nxt;
      hi_wout_r      <= hi_wout_nxt;
      hi_win_r       <= hi_win_nxt;
      lo_reinit_r    <= lo_reinit_nxt;
      hi_reinit_r    <= hi_reinit_nxt;
      reg_rdata      <= rdata_nxt;
    end
  end

  // Controller hookup; the low half trains on clock lane 0
  assign lo_if.enable          = straps_taken_r;
  assign lo_if.master          = lo_master_r;
  assign lo_if.rate_cfg        = lo_rate_r;
  // Unsplit the low half may widen to 16 bits
  assign lo_if.wout_cfg        = split_r ? WIDTH_8 : lo_wout_r;
  assign lo_if.win_cfg         = split_r ? WIDTH_8 : lo_win_r;
  assign lo_if.reinit          = lo_reinit_r;
  assign lo_if.link_clk_edge   = pin_s2_r[0] & ~lclk_last_r[0];
  assign lo_if.peer_power_good = pin_s2_r[2];
  assign lo_if.peer_reset_n    = pin_s2_r[3];
  assign lo_if.peer_stop_n     = pin_s2_r[4];

  assign hi_if.enable          = straps_taken_r & split_r;
  assign hi_if.master          = hi_master_r;
  assign hi_if.rate_cfg        = hi_rate_r;
  assign hi_if.wout_cfg        = WIDTH_8;
  assign hi_if.win_cfg         = WIDTH_8;
  assign hi_if.reinit          = hi_reinit_r;
  assign hi_if.link_clk_edge   = pin_s2_r[1] & ~lclk_last_r[1];
  assign hi_if.peer_power_good = pin_s2_r[5] & split_r;
  assign hi_if.peer_reset_n    = pin_s2_r[6];
  assign hi_if.peer_stop_n     = pin_s2_r[7];

  half_link_ctl u_lo (.core_clk(core_clk), .rst_n(rst_n_r), .c(lo_if));
  half_link_ctl u_hi (.core_clk(core_clk), .rst_n(rst_n_r), .c(hi_if));

  // Registered outputs: routing, bridge bit, lane ownership, sideband
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sel_high_ctl             <= 1'b0;
      bridge_bit_low           <= 1'b0;
      bridge_bit_high          <= 1'b0;
      miss_p2p_resend          <= 1'b0;
      miss_error_resp          <= 1'b0;
      clk_lane_high            <= 2'h0;
      ctl_lane1_used           <= 1'b0;
      ctl_lane1_high           <= 1'b0;
      cad_upper_high           <= 1'b0;
      link_width_16            <= 1'b0;
      low_link_power_good_out  <= 1'b0;
      low_link_power_good_oe   <= 1'b0;
      low_link_reset_n_out     <= 1'b0;
      low_link_reset_n_oe      <= 1'b0;
      low_link_stop_n_out      <= 1'b1;
      low_link_stop_n_oe       <= 1'b0;
      high_link_power_good_out <= 1'b0;
      high_link_power_good_oe  <= 1'b0;
      high_link_reset_n_out    <= 1'b0;
      high_link_reset_n_oe     <= 1'b0;
      high_link_stop_n_out     <= 1'b1;
      high_link_stop_n_oe      <= 1'b0;
    end else begin
      sel_high_ctl    <= split_r & req_addr_bit40;
      bridge_bit_low  <= !lo_down_r;
      bridge_bit_high <= !hi_down_r;
      // Role of the half that owns the request decides miss handling
      miss_p2p_resend <= rx_window_miss &
        !((split_r & req_addr_bit40) ? hi_down_r : lo_down_r);
      miss_error_resp <= rx_window_miss &
        ((split_r & req_addr_bit40) ? hi_down_r : lo_down_r);
      clk_lane_high   <= {split_r, 1'b0};
      ctl_lane1_used  <= split_r;
      ctl_lane1_high  <= split_r;
      cad_upper_high  <= split_r;
      link_width_16   <= !split_r & lo_if.wout_now;
      low_link_power_good_out  <= lo_if.drv_power_good;
      low_link_power_good_oe   <= lo_master_r;
      low_link_reset_n_out     <= lo_if.drv_reset_n;
      low_link_reset_n_oe      <= lo_master_r;
      low_link_stop_n_out      <= lo_if.drv_stop_n;
      low_link_stop_n_oe       <= lo_master_r;
      high_link_power_good_out <= hi_if.drv_power_good;
      high_link_power_good_oe  <= hi_master_r & split_r;
      high_link_reset_n_out    <= hi_if.drv_reset_n;
      high_link_reset_n_oe     <= hi_master_r & split_r;
      high_link_stop_n_out     <= hi_if.drv_stop_n;
      high_link_stop_n_oe      <= hi_master_r & split_r;
    end
  end
endmodule
`default_nettype wire

//--- link_setup_sva.sv
// Checker for lane ownership, request routing and sideband direction
`timescale 1ns/1ps
`default_nettype none
module link_setup_sva (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       reset_n,
  // Straps and requests
  input wire logic       split_link_strap,
  input wire logic       low_link_master_strap,
  input wire logic       high_link_master_strap,
  input wire logic       req_addr_bit40,
  input wire logic       rx_window_miss,
  // Watched outputs
  input wire logic       sel_high_ctl,
  input wire logic       miss_p2p_resend,
  input wire logic       miss_error_resp,
  input wire logic [1:0] clk_lane_high,
  input wire logic       ctl_lane1_used,
  input wire logic       ctl_lane1_high,
  input wire logic       cad_upper_high,
  input wire logic       link_width_16,
  input wire logic       low_link_power_good_oe,
  input wire logic       high_link_power_good_oe,
  input wire logic       high_link_stop_n_oe
);
  logic [2:0] up_r;
  logic [2:0] up_nxt;
  logic       ok;
  // Straps land a few edges after release, so wait before judging
  always_comb up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) up_r <= 3'h0;
    else up_r <= up_nxt;
  end
  assign ok = (up_r == 3'h7);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_sel_route: assert property (ok |=> sel_high_ctl ==
    ($past(req_addr_bit40) && split_link_strap)) else $error("sel route");
  chk_unsplit_low: assert property (ok && !split_link_strap
    |-> !sel_high_ctl [*3]) else $error("high selected unsplit");
  chk_clk_lanes: assert property (ok
    |-> clk_lane_high == {split_link_strap, 1'b0}) else $error("clk lanes");
  chk_ctl_lane: assert property (ok
    |-> ctl_lane1_used == split_link_strap
    && ctl_lane1_high == split_link_strap) else $error("ctl lane");
  chk_cad_lane: assert property (ok
    |-> cad_upper_high == split_link_strap
    && !(link_width_16 && split_link_strap)) else $error("cad lanes");
  chk_hi_idle: assert property (ok && !split_link_strap
    |-> !high_link_power_good_oe && !high_link_stop_n_oe) else $error("hi oe");
  chk_sb_drive: assert property (ok |-> low_link_power_good_oe ==
    low_link_master_strap && (high_link_power_good_oe ==
    (high_link_master_strap && split_link_strap))) else $error("sb oe");
  chk_miss_one: assert property (ok && rx_window_miss
    |=> miss_p2p_resend ^ miss_error_resp) else $error("miss answer");
  cov_high: cover property (ok && sel_high_ctl);
  cov_err: cover property (miss_error_resp);
  cov_wide: cover property (link_width_16);
endmodule
bind link_setup_top link_setup_sva chk_u (.*);
`default_nettype wire

//--- peer_link_model.sv
// Peer device model: sideband levels and gated link clock
`timescale 1ns/1ps
`default_nettype none
module peer_link_model (
  // Wire state
  input  wire logic       split,
  input  wire logic       lo_ok,
  input  wire logic       hi_ok,
  input  wire logic       up,
  // Peer drive
  output logic            drive_lvl,
  output logic [1:0]      link_clk
);
  logic base = 1'b0;
  // Peer holds its sideband low until powered, then releases high
  assign drive_lvl = up;
  // Clock stands still while its half is held in reset
  always #62.5 base = ~base;
  assign link_clk[0] = base & lo_ok;
  assign link_clk[1] = base & (split ? hi_ok : lo_ok);
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the split link setup block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import link_setup_pkg::*;
  logic core_clk = 0, reset_n = 0, split_link_strap = 0, up = 0;
  logic low_link_master_strap = 0, high_link_master_strap = 0;
  logic reg_wr = 0, reg_rd = 0, rd_seen = 0, drive_lvl;
  logic req_addr_bit40 = 0, rx_window_miss = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, ee, mm, b;
  logic [1:0] link_clk_in, clk_lane_high;
  logic [5:0] sb_in, sb_out, sb_oe;
  logic sel_high_ctl, bridge_bit_low, bridge_bit_high, miss_p2p_resend;
  logic miss_error_resp, ctl_lane1_used, ctl_lane1_high, cad_upper_high;
  logic link_width_16;
  int errors = 0, n_tests = 0, cyc = 0;
  logic [31:0] exp_q[$], msk_q[$];
  always #5 core_clk = ~core_clk;
  // Each pin shows whoever enables it, else the peer level
  assign sb_in = (sb_oe & sb_out) | (~sb_oe & {6{drive_lvl}});
  peer_link_model pm_u (.split(split_link_strap), .up(up),
    .lo_ok(sb_in[0] & sb_in[1]), .hi_ok(sb_in[3] & sb_in[4]),
    .drive_lvl(drive_lvl), .link_clk(link_clk_in));
  link_setup_top dut_u (.*,
    .low_link_power_good_in(sb_in[0]), .low_link_power_good_out(sb_out[0]),
    .low_link_power_good_oe(sb_oe[0]), .low_link_reset_n_in(sb_in[1]),
    .low_link_reset_n_out(sb_out[1]), .low_link_reset_n_oe(sb_oe[1]),
    .low_link_stop_n_in(sb_in[2]), .low_link_stop_n_out(sb_out[2]),
    .low_link_stop_n_oe(sb_oe[2]), .high_link_power_good_in(sb_in[3]),
    .high_link_power_good_out(sb_out[3]), .high_link_power_good_oe(sb_oe[3]),
    .high_link_reset_n_in(sb_in[4]), .high_link_reset_n_out(sb_out[4]),
    .high_link_reset_n_oe(sb_oe[4]), .high_link_stop_n_in(sb_in[5]),
    .high_link_stop_n_out(sb_out[5]), .high_link_stop_n_oe(sb_oe[5]));
  task automatic conclude();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Read data stands one cycle only, so it is taken at that edge
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      conclude();
    end else begin
      if (rd_seen && exp_q.size() > 0) begin
        ee = exp_q.pop_front();
        mm = msk_q.pop_front();
        if (mm !== '0) cmp("reg_rdata", ee, reg_rdata & mm);
      end
      rd_seen <= reg_rd;
    end
  end
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e,
                        input logic [31:0] m, output logic [31:0] v);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wait_done(input logic h);
    logic [31:0] v;
    for (int i = 0; i < 2000; i++) begin
      rd_reg(h ? OFS_HI_STATUS : OFS_LO_STATUS, 0, 0, v);
      if (v[ST_DONE_BIT] === 1'b1) break;
    end
    cmp("init_done", 1, v[ST_DONE_BIT]);
  endtask
  task automatic run_cfg(input logic s, input logic lm, input logic hm,
                         input logic [1:0] r);
    logic [31:0] v;
    logic h;
    logic own;
    h = s & hm;
    @(posedge core_clk);
    reset_n <= 1'b0;
    up <= 1'b0;
    split_link_strap <= s;
    low_link_master_strap <= lm;
    high_link_master_strap <= hm;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    up <= 1'b1;
    #1 cmp("bridge_bit_low", lm, bridge_bit_low);
    if (s) cmp("bridge_bit_high", hm, bridge_bit_high);
    cmp("clk_lane_high", {s, 1'b0}, clk_lane_high);
    cmp("ctl_lane1", {s, s}, {ctl_lane1_used, ctl_lane1_high});
    cmp("cad_upper_high", s, cad_upper_high);
    cmp("sb_oe", {{3{s & hm}}, {3{lm}}}, sb_oe);
    cmp("sb_out", 6'b101101, sb_out);
    rd_reg(OFS_MODE, {hm, lm, s, 4'h0}, 32'h70, v);
    rd_reg(OFS_LO_CONFIG, 32'(!lm) << CFG_DOWN_BIT, 32'h100, v);
    rd_reg(4'h9, 0, '1, v);
    wait_done(1'b0);
    if (s) wait_done(1'b1);
    rd_reg(OFS_LO_STATUS, 32'h1, 32'h331, v);
    if (!s) rd_reg(OFS_HI_STATUS, 0, '1, v);
    repeat (8) begin
      b = $urandom;
      @(posedge core_clk);
      req_addr_bit40 <= b[0];
      rx_window_miss <= 1'b1;
      @(posedge core_clk);
      rx_window_miss <= 1'b0;
      own = (s && b[0]) ? hm : lm;
      #1 cmp("sel_high_ctl", s & b[0], sel_high_ctl);
      cmp("miss_p2p_resend", own, miss_p2p_resend);
      cmp("miss_error_resp", !own, miss_error_resp);
    end
    wr_reg(h ? OFS_HI_CONFIG : OFS_LO_CONFIG, 32'h30 | 32'(r));
    rd_reg(h ? OFS_HI_STATUS : OFS_LO_STATUS, 32'h1, 32'h331, v);
    wr_reg(OFS_MODE, 32'h1 << h);
    repeat (20) @(posedge core_clk);
    wr_reg(OFS_MODE, 32'h0);
    wait_done(h);
    v = 32'({r, 8'h01}) | (s ? 32'h0 : 32'h30);
    rd_reg(h ? OFS_HI_STATUS : OFS_LO_STATUS, v, 32'h331, v);
    if (s) rd_reg(h ? OFS_LO_STATUS : OFS_HI_STATUS, 1, 32'h301, v);
    #1 cmp("link_width_16", !s, link_width_16);
  endtask
  initial begin
    b = $urandom(32'h45ca225d);
    run_cfg(1'b0, 1'b1, 1'b0, 2'h2);
    run_cfg(1'b1, 1'b1, 1'b0, 2'h1);
    run_cfg(1'b1, 1'b0, 1'b1, 2'h2);
    conclude();
  end
endmodule
`default_nettype wire
